/* hw/usbf_defines.vh */
// Register map, field positions, reset values and FIFO layout of the USB support core
`ifndef USBF_DEFINES_VH
`define USBF_DEFINES_VH

// ----------------------------------------------------------------
// Indirect register addresses
// ----------------------------------------------------------------
`define USBF_A_FNADDR   6'h00
`define USBF_A_INDEX    6'h0e
`define USBF_A_CRCTL    6'h0f
`define USBF_A_INCSRH   6'h12
`define USBF_A_OUTCSRH  6'h15
`define USBF_A_MPIN     6'h18
`define USBF_A_MPOUT    6'h19
`define USBF_A_FIFO0    6'h20
`define USBF_A_FIFO3    6'h23

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define USBF_ADR_BUSY   7
`define USBF_ADR_AUTORD 6
`define USBF_CR_ENABLE  7
`define USBF_CR_SSTEP   6
`define USBF_CR_LOW     5
`define USBF_CRCTL_RST  8'h0f
`define USBF_IN_DBUF    7
`define USBF_IN_DIR     5
`define USBF_IN_SPLIT   2
`define USBF_OUT_DBUF   7
`define USBF_MP_SHIFT   3

// ----------------------------------------------------------------
// FIFO space: 1024 bytes, offsets from the FIFO base in XRAM
// ----------------------------------------------------------------
`define USBF_XRAM_BASE  16'h0400
`define USBF_FIFO_BYTES 1024
`define USBF_EP0_BASE   10'h3c0
`define USBF_EP1_BASE   10'h340
`define USBF_EP2_BASE   10'h240
`define USBF_EP3_BASE   10'h040
`define USBF_EP0_SIZE   10'd64
`define USBF_EP1_SIZE   10'd128
`define USBF_EP2_SIZE   10'd256
`define USBF_EP3_SIZE   10'd512

// ----------------------------------------------------------------
// Oscillator trim
// ----------------------------------------------------------------
`define USBF_TRIM_RST   7'h40
`define USBF_TRIM_MAX   7'h7f
`define USBF_STEP_NORM  7'd4
`define USBF_STEP_SS    7'd1

`endif

/* hw/usbf_fifo_ram.v */
// Endpoint FIFO storage: 1024 x 8 single-port memory with registered read data
`include "usbf_defines.vh"

module usbf_fifo_ram (
  input  wire       clk,
  input  wire       we,
  input  wire       re,
  input  wire [9:0] addr,
  input  wire [7:0] wdata,
  output reg  [7:0] rdata
);

  reg [7:0] mem [0:`USBF_FIFO_BYTES-1];

  // One access per cycle; read data valid the cycle after re
  always @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    if (re) begin
      rdata <= mem[addr];
    end
  end

endmodule // usbf_fifo_ram

/* hw/usbf_skid2.v */
// Two-entry valid/ready buffer on the IN byte path toward the bus engine
module usbf_skid2 (
  input  wire       clk,
  input  wire       rst_b,
  input  wire       flush,
  input  wire       s_valid,
  input  wire [7:0] s_data,
  output wire       s_ready,
  output wire       m_valid,
  output wire [7:0] m_data,
  input  wire       m_ready
);

  reg [7:0] slot0;
  reg [7:0] slot1;
  reg [1:0] fill;

  wire push = s_valid & s_ready;
  wire pop  = m_valid & m_ready;

  // Honest full and empty straight from the fill count
  assign s_ready = (fill != 2'd2);
  assign m_valid = (fill != 2'd0);
  assign m_data  = slot0;

  // Slot0 is always the head; slot1 shifts down on a pop
  always @(posedge clk) begin
    if (!rst_b || flush) begin
      fill  <= 2'd0;
      slot0 <= 8'h00;
      slot1 <= 8'h00;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (fill == 2'd0) slot0 <= s_data;
          else slot1 <= s_data;
          fill <= fill + 2'd1;
        end
        2'b01: begin
          slot0 <= slot1;
          fill  <= fill - 2'd1;
        end
        2'b11: begin
          if (fill == 2'd1) slot0 <= s_data;
          else begin
            slot0 <= slot1;
            slot1 <= s_data;
          end
        end
        default: begin
          fill <= fill;
        end
      endcase
    end
  end

endmodule // usbf_skid2

/* hw/usbf_core.v */
// USB function support core: clock recovery control, endpoint FIFOs, function address
`include "usbf_defines.vh"

module usbf_core (
  input  wire       clk,
  input  wire       rst_b,
  input  wire       adr_we,
  input  wire [7:0] adr_wdata,
  output wire [7:0] adr_rdata,
  input  wire       dat_we,
  input  wire [7:0] dat_wdata,
  input  wire       dat_re,
  output reg  [7:0] dat_rdata,
  input  wire       full_speed,
  output reg        fn_low_speed,
  input  wire       cr_osc_fast,
  input  wire       cr_osc_slow,
  output reg  [6:0] osc_trim,
  output wire       cr_active,
  output wire       cr_single_step,
  output wire       cr_low_speed,
  input  wire       bus_reset,
  input  wire       xfer_end,
  input  wire [6:0] tok_addr,
  output wire       addr_match,
  input  wire       usb_out_valid,
  input  wire [1:0] usb_out_ep,
  input  wire [7:0] usb_out_data,
  output reg        usb_out_ready,
  input  wire       usb_in_req,
  input  wire [1:0] usb_in_ep,
  output wire       usb_in_valid,
  output wire [7:0] usb_in_data,
  input  wire       usb_in_ready
);

  // ----------------------------------------------------------------
  // States and storage
  // ----------------------------------------------------------------
  localparam [1:0] S_IDLE  = 2'b00;
  localparam [1:0] S_FW_RD = 2'b01;
  localparam [1:0] S_IN_RD = 2'b10;

  reg  [1:0] state;
  reg  [1:0] next_state;
  reg  [5:0] areg;
  reg        autord;
  reg        fw_pend;
  reg        fw_is_rd;
  reg  [7:0] fw_wdata;
  reg  [6:0] new_addr;
  reg  [6:0] active_addr;
  reg        addr_upd;
  reg  [3:0] ep_index;
  reg  [7:0] cr_reg;
  reg  [3:0] split_r;
  reg  [3:0] dir_in_r;
  reg  [3:0] dbuf_in_r;
  reg  [3:0] dbuf_out_r;
  reg  [9:0] wp  [0:7];
  reg  [9:0] rp  [0:7];
  reg  [9:0] cnt [0:7];
  integer    i;

  // ----------------------------------------------------------------
  // Layout functions
  // ----------------------------------------------------------------
  // fixed region sizes
  function [9:0] f_size;
    input [1:0] ep;
    input       split;
    reg   [9:0] full;
    begin
      full = `USBF_EP0_SIZE;
      case (ep)
        2'd1:    full = `USBF_EP1_SIZE;
        2'd2:    full = `USBF_EP2_SIZE;
        2'd3:    full = `USBF_EP3_SIZE;
        default: full = `USBF_EP0_SIZE;
      endcase
      f_size = split ? (full >> 1) : full;
    end
  endfunction

  // split IN half sits above OUT
  function [9:0] f_base;
    input [1:0] ep;
    input       split;
    input       in_half;
    reg   [9:0] b;
    begin
      b = `USBF_EP0_BASE;
      case (ep)
        2'd1:    b = `USBF_EP1_BASE;
        2'd2:    b = `USBF_EP2_BASE;
        2'd3:    b = `USBF_EP3_BASE;
        default: b = `USBF_EP0_BASE;
      endcase
      f_base = (split && in_half) ? (b + f_size(ep, 1'b1)) : b;
    end
  endfunction

  // max packet, in units of 8 bytes
  function [7:0] f_maxpkt;
    input [1:0] ep;
    input       split;
    input       dbuf;
    reg   [9:0] m;
    begin
      m = f_size(ep, split);
      if (dbuf && ep != 2'd0) m = m >> 1;
      f_maxpkt = {1'b0, m[9:`USBF_MP_SHIFT]};
    end
  endfunction

  // Split never applies to endpoint 0
  wire [3:0] split_eff = {split_r[3:1], 1'b0};

  // unsplit pair of endpoints 1 to 3 only moves in the selected direction
  function f_dir_ok;
    input [1:0] ep;
    input       want_in;
    begin
      f_dir_ok = (ep == 2'd0) || split_eff[ep] || (dir_in_r[ep] == want_in);
    end
  endfunction

  // ----------------------------------------------------------------
  // FIFO operation select
  // ----------------------------------------------------------------
  wire [1:0] fw_ep     = areg[1:0];
  wire       fw_is_fifo = (areg >= `USBF_A_FIFO0) && (areg <= `USBF_A_FIFO3);
  wire [2:0] fw_in_f   = {fw_ep, split_eff[fw_ep]};
  wire [2:0] fw_out_f  = {fw_ep, 1'b0};
  wire [2:0] uo_f      = {usb_out_ep, 1'b0};
  wire [2:0] ui_f      = {usb_in_ep, split_eff[usb_in_ep]};
  wire       buf_ready;
  wire [7:0] ram_rdata;

  reg        op_wr;
  reg        op_rd;
  reg  [2:0] op_f;
  reg  [7:0] op_wdata;

  wire [9:0] op_size = f_size(op_f[2:1], split_eff[op_f[2:1]]);
  wire [9:0] op_base = f_base(op_f[2:1], split_eff[op_f[2:1]], op_f[0]);
  wire [9:0] ram_addr = op_base + (op_wr ? wp[op_f] : rp[op_f]);

  // Firmware first, then OUT bytes, then IN prefetch
  always @* begin
    next_state    = state;
    op_wr         = 1'b0;
    op_rd         = 1'b0;
    op_f          = 3'd0;
    op_wdata      = fw_wdata;
    usb_out_ready = 1'b0;
    case (state)
      S_IDLE: begin
        if (fw_pend) begin
          if (fw_is_rd && fw_is_fifo) begin
            // port read drains the OUT side
            op_f = fw_out_f;
            if (cnt[fw_out_f] != 10'd0 && f_dir_ok(fw_ep, 1'b0)) begin
              op_rd      = 1'b1;
              next_state = S_FW_RD;
            end
          end else if (!fw_is_rd && fw_is_fifo) begin
            // port write fills the IN side
            op_f = fw_in_f;
            op_wr = (cnt[fw_in_f] != f_size(fw_ep, split_eff[fw_ep])) && f_dir_ok(fw_ep, 1'b1);
          end
        end else if (usb_out_valid && f_dir_ok(usb_out_ep, 1'b0) &&
                     cnt[uo_f] != f_size(usb_out_ep, split_eff[usb_out_ep])) begin
          op_f          = uo_f;
          op_wdata      = usb_out_data;
          op_wr         = 1'b1;
          usb_out_ready = 1'b1;
        end else if (usb_in_req && buf_ready && cnt[ui_f] != 10'd0 &&
                     f_dir_ok(usb_in_ep, 1'b1)) begin
          op_f       = ui_f;
          op_rd      = 1'b1;
          next_state = S_IN_RD;
        end
      end
      S_FW_RD: next_state = S_IDLE;
      S_IN_RD: next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // FIFO pointers
  // ----------------------------------------------------------------
  // wrap pointers inside each region
  always @(posedge clk) begin
    if (!rst_b || bus_reset) begin
      for (i = 0; i < 8; i = i + 1) begin
        wp[i]  <= 10'd0;
        rp[i]  <= 10'd0;
        cnt[i] <= 10'd0;
      end
    end else if (op_wr) begin
      wp[op_f]  <= (wp[op_f] + 10'd1 == op_size) ? 10'd0 : wp[op_f] + 10'd1;
      cnt[op_f] <= cnt[op_f] + 10'd1;
    end else if (op_rd) begin
      rp[op_f]  <= (rp[op_f] + 10'd1 == op_size) ? 10'd0 : rp[op_f] + 10'd1;
      cnt[op_f] <= cnt[op_f] - 10'd1;
    end
  end

  usbf_fifo_ram u_ram (
    .clk   (clk),
    .we    (op_wr),
    .re    (op_rd),
    .addr  (ram_addr),
    .wdata (op_wdata),
    .rdata (ram_rdata)
  );

  // Prefetch issues only when the buffer has room, so nothing is lost
  usbf_skid2 u_inbuf (
    .clk     (clk),
    .rst_b   (rst_b),
    .flush   (bus_reset),
    .s_valid (state == S_IN_RD),
    .s_data  (ram_rdata),
    .s_ready (buf_ready),
    .m_valid (usb_in_valid),
    .m_data  (usb_in_data),
    .m_ready (usb_in_ready)
  );

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  wire [1:0] ix   = ep_index[1:0];
  wire       ix_ok = (ep_index < 4'd4);
  reg  [7:0] reg_rd;

  always @* begin
    reg_rd = 8'h00;
    case (areg)
      `USBF_A_FNADDR:  reg_rd = {addr_upd, new_addr};
      `USBF_A_INDEX:   reg_rd = {4'h0, ep_index};
      `USBF_A_CRCTL:   reg_rd = cr_reg;
      `USBF_A_INCSRH:  reg_rd = ix_ok ? {dbuf_in_r[ix], 1'b0, dir_in_r[ix], 2'b00,
                                         split_eff[ix], 2'b00} : 8'h00;
      `USBF_A_OUTCSRH: reg_rd = ix_ok ? {dbuf_out_r[ix], 7'h00} : 8'h00;
      `USBF_A_MPIN:    reg_rd = ix_ok ? f_maxpkt(ix, split_eff[ix], dbuf_in_r[ix]) : 8'h00;
      // OUT half has its own setting when split
      `USBF_A_MPOUT:   reg_rd = ix_ok ? f_maxpkt(ix, split_eff[ix],
                                split_eff[ix] ? dbuf_out_r[ix] : dbuf_in_r[ix]) : 8'h00;
      default:         reg_rd = 8'h00;
    endcase
  end

  // busy while a data access is in progress
  assign adr_rdata = {fw_pend, autord, areg};

  // ----------------------------------------------------------------
  // Indirect access and control registers
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_b) begin
      state      <= S_IDLE;
      areg       <= 6'h00;
      autord     <= 1'b0;
      fw_pend    <= 1'b0;
      fw_is_rd   <= 1'b0;
      fw_wdata   <= 8'h00;
      dat_rdata  <= 8'h00;
      new_addr   <= 7'h00;
      active_addr <= 7'h00;
      addr_upd   <= 1'b0;
      ep_index   <= 4'h0;
      cr_reg     <= `USBF_CRCTL_RST;
      split_r    <= 4'h0;
      dir_in_r   <= 4'h0;
      dbuf_in_r  <= 4'h0;
      dbuf_out_r <= 4'h0;
    end else begin
      state <= next_state;
      // new address only at end of transfer
      if (xfer_end && addr_upd) begin
        active_addr <= new_addr;
        addr_upd    <= 1'b0;
      end
      if (!fw_pend) begin
        if (adr_we) begin
          areg   <= adr_wdata[5:0];
          autord <= adr_wdata[`USBF_ADR_AUTORD];
          if (adr_wdata[`USBF_ADR_BUSY]) begin
            fw_pend  <= 1'b1;
            fw_is_rd <= 1'b1;
          end
        end else if (dat_we) begin
          fw_wdata <= dat_wdata;
          fw_pend  <= 1'b1;
          fw_is_rd <= 1'b0;
        end else if (dat_re && autord) begin
          // Auto-read: taking the data starts the next fetch
          fw_pend  <= 1'b1;
          fw_is_rd <= 1'b1;
        end
      end
      // Service the pending firmware access
      if (state == S_FW_RD) begin
        dat_rdata <= ram_rdata;
        fw_pend   <= 1'b0;
      end else if (state == S_IDLE && fw_pend) begin
        if (fw_is_rd) begin
          if (!op_rd) begin
            // Empty or wrong-way FIFO reads as zero
            dat_rdata <= fw_is_fifo ? 8'h00 : reg_rd;
            fw_pend   <= 1'b0;
          end
        end else begin
          fw_pend <= 1'b0;
          case (areg)
            `USBF_A_FNADDR: begin
              new_addr <= fw_wdata[6:0];
              // pending flag set; set beats the clear
              addr_upd <= 1'b1;
            end
            `USBF_A_INDEX:  ep_index <= fw_wdata[3:0];
            `USBF_A_CRCTL:  cr_reg <= fw_wdata;
            `USBF_A_INCSRH: begin
              if (ix_ok) begin
                dbuf_in_r[ix] <= fw_wdata[`USBF_IN_DBUF];
                dir_in_r[ix]  <= fw_wdata[`USBF_IN_DIR];
                split_r[ix]   <= fw_wdata[`USBF_IN_SPLIT];
              end
            end
            `USBF_A_OUTCSRH: begin
              if (ix_ok) dbuf_out_r[ix] <= fw_wdata[`USBF_OUT_DBUF];
            end
            default: fw_pend <= 1'b0;
          endcase
        end
      end
      if (bus_reset) begin
        new_addr    <= 7'h00;
        active_addr <= 7'h00;
        addr_upd    <= 1'b0;
        ep_index    <= 4'h0;
      end
    end
  end

  // Old address keeps answering until the switch
  assign addr_match = (tok_addr == active_addr);

  // ----------------------------------------------------------------
  // Clock recovery and speed
  // ----------------------------------------------------------------
  assign cr_active      = cr_reg[`USBF_CR_ENABLE];
  assign cr_single_step = cr_reg[`USBF_CR_SSTEP];
  // low-speed recovery mode to the detector
  assign cr_low_speed   = cr_reg[`USBF_CR_LOW];

  // single step uses the small trim step
  wire [6:0] trim_step = cr_reg[`USBF_CR_SSTEP] ? `USBF_STEP_SS : `USBF_STEP_NORM;
  wire [7:0] trim_up   = {1'b0, osc_trim} + {1'b0, trim_step};

  // trim only while recovery is enabled; saturate at both ends
  always @(posedge clk) begin
    if (!rst_b) begin
      osc_trim     <= `USBF_TRIM_RST;
      fn_low_speed <= 1'b0;
    end else begin
      fn_low_speed <= ~full_speed;
      if (cr_reg[`USBF_CR_ENABLE] && (cr_osc_fast ^ cr_osc_slow)) begin
        if (cr_osc_fast) begin
          osc_trim <= (osc_trim < trim_step) ? 7'h00 : osc_trim - trim_step;
        end else begin
          osc_trim <= trim_up[7] ? `USBF_TRIM_MAX : trim_up[6:0];
        end
      end
    end
  end

endmodule // usbf_core

/* dv/usbf_core_props.sv */
// Port-level assertions for the USB support core
module usbf_core_props (
  input wire       clk,
  input wire       rst_b,
  input wire       adr_we,
  input wire [7:0] adr_wdata,
  input wire [7:0] adr_rdata,
  input wire       full_speed,
  input wire       fn_low_speed,
  input wire       cr_osc_fast,
  input wire       cr_osc_slow,
  input wire [6:0] osc_trim,
  input wire       cr_active,
  input wire       cr_single_step,
  input wire       bus_reset,
  input wire       xfer_end,
  input wire [6:0] tok_addr,
  input wire       addr_match,
  input wire       usb_in_valid,
  input wire [7:0] usb_in_data,
  input wire       usb_in_ready
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // ----------------------------------------------------------------
  // Speed and clock recovery
  // ----------------------------------------------------------------
  a_speed_follow: assert property (1'b1 |=> fn_low_speed == !$past(full_speed))
    else $error("low speed flag does not follow speed bit");
  a_trim_frozen: assert property (!cr_active |=> $stable(osc_trim))
    else $error("trim moved with recovery off");
  a_trim_both: assert property (cr_osc_fast && cr_osc_slow |=> $stable(osc_trim))
    else $error("trim moved on conflicting pulses");
  // Saturation guard keeps the step check away from the ends of the range
  a_step_normal: assert property (cr_active && !cr_single_step && (cr_osc_fast ^ cr_osc_slow)
    && osc_trim > 7'd3 && osc_trim < 7'h7c
    |=> osc_trim == $past(osc_trim) + 7'd4 || osc_trim == $past(osc_trim) - 7'd4)
    else $error("normal trim step is not 4");
  a_step_single: assert property (cr_active && cr_single_step && (cr_osc_fast ^ cr_osc_slow)
    && osc_trim > 7'd0 && osc_trim < 7'h7f
    |=> osc_trim == $past(osc_trim) + 7'd1 || osc_trim == $past(osc_trim) - 7'd1)
    else $error("single trim step is not 1");
  // ----------------------------------------------------------------
  // Address, indirect port and IN buffer
  // ----------------------------------------------------------------
  a_match_steady: assert property (!xfer_end && !bus_reset ##1 $stable(tok_addr)
    |-> $stable(addr_match))
    else $error("active address changed outside transfer end");
  a_reset_addr: assert property (bus_reset |=> addr_match == (tok_addr == 7'h00))
    else $error("bus reset left address nonzero");
  a_busy_rise: assert property (adr_we && adr_wdata[7] && !adr_rdata[7] |=> adr_rdata[7])
    else $error("busy did not rise on read start");
  a_busy_bound: assert property ($rose(adr_rdata[7]) |-> ##[1:4] !adr_rdata[7])
    else $error("busy held too long");
  // A stalled byte must wait unchanged, otherwise it is lost
  a_in_hold: assert property (usb_in_valid && !usb_in_ready && !bus_reset
    |=> usb_in_valid && $stable(usb_in_data))
    else $error("stalled IN byte changed or vanished");
  a_in_flush: assert property (bus_reset |=> !usb_in_valid)
    else $error("IN buffer kept data over bus reset");
endmodule // usbf_core_props

bind usbf_core usbf_core_props u_props (
  .clk(clk), .rst_b(rst_b), .adr_we(adr_we), .adr_wdata(adr_wdata),
  .adr_rdata(adr_rdata), .full_speed(full_speed), .fn_low_speed(fn_low_speed),
  .cr_osc_fast(cr_osc_fast), .cr_osc_slow(cr_osc_slow), .osc_trim(osc_trim),
  .cr_active(cr_active), .cr_single_step(cr_single_step), .bus_reset(bus_reset),
  .xfer_end(xfer_end), .tok_addr(tok_addr), .addr_match(addr_match),
  .usb_in_valid(usb_in_valid), .usb_in_data(usb_in_data), .usb_in_ready(usb_in_ready));

/* dv/usbf_host_model.sv */
// Host model: sends OUT bytes, collects IN bytes under random stalls
module usbf_host_model (
  output reg        usb_out_valid,
  output reg  [1:0] usb_out_ep,
  output reg  [7:0] usb_out_data,
  output reg        usb_in_req,
  output reg  [1:0] usb_in_ep,
  output reg        usb_in_ready,
  input  wire       clk,
  input  wire       usb_out_ready,
  input  wire       usb_in_valid,
  input  wire [7:0] usb_in_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  integer     seed = 64;
  reg         stall = 1'b1;
  // ----------------------------------------------------------------
  // IN side: byte taken only on valid and ready at the edge
  // ----------------------------------------------------------------
  initial begin
    {usb_out_valid, usb_out_ep, usb_out_data} = 11'h000;
    {usb_in_req, usb_in_ep, usb_in_ready} = 4'h0;
  end
  always @(posedge clk) begin
    if (usb_in_valid && usb_in_ready)
      got.push_back(usb_in_data);
    #1 usb_in_ready = !stall & $random(seed); // Random stalls
  end
  // one byte a handshake; line shows inverse once released
  task send(input [1:0] ep, input [7:0] b);
    integer j;
    reg     g;
    begin
      {usb_out_valid, usb_out_ep, usb_out_data} = {1'b1, ep, b};
      g = 1'b0;
      for (j = 0; j < 30 && !g; j = j + 1) begin
        @(negedge clk);
        g = usb_out_ready;
        @(posedge clk);
        #1;
      end
      usb_out_valid = 1'b0;
      usb_out_data = ~b;
    end
  endtask
endmodule // usbf_host_model

/* dv/tb.sv */
// Self-checking bench for the USB support core with a host model
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  reg        clk, rst_b, adr_we, dat_we, dat_re, full_speed;
  reg        cr_osc_fast, cr_osc_slow, bus_reset, xfer_end;
  reg  [7:0] adr_wdata, dat_wdata, v, d;
  reg  [6:0] tok_addr;
  wire [7:0] adr_rdata, dat_rdata, od, id;
  wire [6:0] osc_trim;
  wire [1:0] oep, iep;
  wire       fls, cra, crs, crl, am, ov, ordy, ireq, iv, ir;
  integer    n_mismatch, checks_done, seed, cyc, i, k;
  reg  [7:0] q[$];

  usbf_core dut (
    .clk(clk), .rst_b(rst_b), .adr_we(adr_we), .adr_wdata(adr_wdata),
    .adr_rdata(adr_rdata), .dat_we(dat_we), .dat_wdata(dat_wdata), .dat_re(dat_re),
    .dat_rdata(dat_rdata), .full_speed(full_speed), .fn_low_speed(fls),
    .cr_osc_fast(cr_osc_fast), .cr_osc_slow(cr_osc_slow), .osc_trim(osc_trim),
    .cr_active(cra), .cr_single_step(crs), .cr_low_speed(crl), .bus_reset(bus_reset),
    .xfer_end(xfer_end), .tok_addr(tok_addr), .addr_match(am), .usb_out_valid(ov),
    .usb_out_ep(oep), .usb_out_data(od), .usb_out_ready(ordy), .usb_in_req(ireq),
    .usb_in_ep(iep), .usb_in_valid(iv), .usb_in_data(id), .usb_in_ready(ir));
  usbf_host_model host (
    .clk(clk), .usb_out_valid(ov), .usb_out_ep(oep), .usb_out_data(od),
    .usb_out_ready(ordy), .usb_in_req(ireq), .usb_in_ep(iep), .usb_in_valid(iv),
    .usb_in_data(id), .usb_in_ready(ir));

  // ----------------------------------------------------------------
  // Clock, hang guard and shared tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // The whole sequence needs well under this many cycles
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 6000) begin
      n_mismatch = n_mismatch + 1;
      complete_run;
    end
  end
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // Bounded wait for busy low; one edge first so busy can rise
  task idle;
    integer j;
    begin
      @(posedge clk);
      #1;
      for (j = 0; j < 20 && adr_rdata[7] !== 1'b0; j = j + 1) begin
        @(posedge clk);
        #1;
      end
    end
  endtask
  task aw(input [7:0] a);
    begin
      {adr_we, adr_wdata} = {1'b1, a};
      @(posedge clk);
      #1 adr_we = 1'b0;
      idle;
    end
  endtask
  task wr(input [5:0] a, input [7:0] b);
    begin
      aw({2'b00, a});
      {dat_we, dat_wdata} = {1'b1, b};
      @(posedge clk);
      #1 dat_we = 1'b0;
      idle;
    end
  endtask
  task rd(input [5:0] a, output [7:0] r);
    begin
      aw({2'b10, a});
      r = dat_rdata;
    end
  endtask
  task pulse(input [1:0] m);
    begin
      {cr_osc_slow, cr_osc_fast} = m;
      @(posedge clk);
      #1 {cr_osc_slow, cr_osc_fast} = 2'b00;
      @(posedge clk);
      #1;
    end
  endtask
  task complete_run;
    begin
      if (n_mismatch == 0 && checks_done > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_b, adr_we, dat_we, dat_re, cr_osc_fast, cr_osc_slow, bus_reset, xfer_end} = 8'h00;
    {adr_wdata, dat_wdata, tok_addr} = 23'h0;
    full_speed = 1'b1;
    n_mismatch = 0;
    checks_done = 0;
    seed = 64;
    cyc = 0;
    repeat (3) @(posedge clk);
    #1 rst_b = 1'b1;
    chk(adr_rdata, 8'h00);
    chk({1'b0, osc_trim}, 8'h40);
    chk({7'h0, am}, 8'h01);
    rd(6'h0f, v);
    chk(v, 8'h0f);
    pulse(2'b10);
    chk({1'b0, osc_trim}, 8'h40);
    // speed picked, recovery on, low bit (k=0) or single step (k=1) set, reserved bits 01111b
    for (k = 0; k < 2; k = k + 1) begin
      full_speed = k;
      wr(6'h0f, k ? 8'hcf : 8'haf);
      chk({4'h0, fls, cra, crs, crl}, k ? 8'h06 : 8'h0d);
      pulse(2'b10);
      v = {1'b0, osc_trim};
      chk(v > 8'h40 ? v - 8'h40 : 8'h40 - v, k ? 8'h01 : 8'h04);
      pulse(2'b01);
      chk({1'b0, osc_trim}, 8'h40);
      pulse(2'b11);
      chk({1'b0, osc_trim}, 8'h40);
    end
    rd(6'h0f, v);
    chk(v, 8'hcf);
    // packet limit for endpoints 1 to 3, split and double buffer
    for (i = 1; i < 4; i = i + 1) begin
      for (k = 0; k < 4; k = k + 1) begin
        wr(6'h0e, i);
        wr(6'h12, {k[0], 4'h0, k[1], 2'b00});
        rd(6'h18, v);
        chk(v, (64 << i) >> (k[0] + k[1] + 3));
      end
    end
    wr(6'h15, 8'h80);
    rd(6'h19, v);
    chk(v, 8'h10);
    wr(6'h0e, 8'h04);
    rd(6'h12, v);
    chk(v, 8'h00);
    rd(6'h3f, v);
    chk(v, 8'h00);
    // split endpoint 1: port writes feed IN, buffer fills while stalled
    wr(6'h0e, 8'h01);
    wr(6'h12, 8'h04);
    for (i = 0; i < 6; i = i + 1) begin
      v = $random(seed);
      q.push_back(v);
      wr(6'h21, v);
    end
    host.usb_in_ep = 2'd1;
    host.usb_in_req = 1'b1;
    repeat (12) @(posedge clk);
    #1 chk({7'h0, iv}, 8'h01);
    chk(host.got.size(), 8'h00);
    host.stall = 1'b0;
    for (i = 0; i < 200 && host.got.size() < 6; i = i + 1) @(posedge clk);
    #1 host.usb_in_req = 1'b0;
    chk(host.got.size(), 8'h06);
    for (i = 0; i < 6; i = i + 1) chk(host.got[i], q[i]);
    // OUT bytes read back in order, enough to wrap the region
    for (i = 0; i < 90; i = i + 1) begin
      v = $random(seed);
      host.send(2'd1, v);
      rd(6'h21, d);
      chk(d, v);
    end
    rd(6'h21, d);
    chk(d, 8'h00);
    // Autoread: taking the data word starts the next FIFO fetch
    host.send(2'd1, 8'h11);
    @(posedge clk);
    #1 host.send(2'd1, 8'h22);
    aw(8'he1);
    chk(dat_rdata, 8'h11);
    dat_re = 1'b1;
    @(posedge clk);
    #1 dat_re = 1'b0;
    idle;
    chk(dat_rdata, 8'h22);
    // new address waits for the end of the transfer
    v = ($random(seed) & 8'h7f) | 8'h01;
    wr(6'h00, v);
    rd(6'h00, d);
    chk(d, v | 8'h80);
    tok_addr = v[6:0];
    #1 chk({7'h0, am}, 8'h00);
    @(posedge clk);
    #1 xfer_end = 1'b1;
    @(posedge clk);
    #1 xfer_end = 1'b0;
    chk({7'h0, am}, 8'h01);
    rd(6'h00, d);
    chk(d, v);
    // unsplit endpoint 2 is one FIFO, used one way at a time
    wr(6'h0e, 8'h02);
    wr(6'h12, 8'h20);
    wr(6'h22, 8'h3c);
    rd(6'h22, d);
    chk(d, 8'h00);
    wr(6'h12, 8'h00);
    rd(6'h22, d);
    chk(d, 8'h3c);
    // bus reset clears address and empties the FIFOs and the IN buffer
    host.stall = 1'b1;
    host.usb_in_ep = 2'd0;
    host.usb_in_req = 1'b1;
    for (k = 0; k < 3; k = k + 1) wr(6'h20, 8'h5a ^ k);
    chk({7'h0, iv}, 8'h01);
    bus_reset = 1'b1;
    @(posedge clk);
    #1 bus_reset = 1'b0;
    host.usb_in_req = 1'b0;
    chk({7'h0, iv}, 8'h00);
    chk({7'h0, am}, 8'h00);
    rd(6'h00, d);
    chk(d, 8'h00);
    rd(6'h20, d);
    chk(d, 8'h00);
    complete_run;
  end
endmodule // tb
